// ===== design/cis_pkg.sv
// Constants, register map and types for the core interrupt source block
package cis_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int PC_W   = 13;
  localparam int EV_W   = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CORE_CTL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PFLAGS1   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PFLAGS2   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PENABLE1  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PENABLE2  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OPTION    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PIN_MASK  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_TICK      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PORT      = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SLEEP     = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_EV_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_EV_CLEAR  = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_EV_ENABLE = 8'h30;

  // Core control bit positions
  localparam int B_GLOBAL_EN  = 7;
  localparam int B_PERIPH_EN  = 6;
  localparam int B_TIMER_EN   = 5;
  localparam int B_EXT_EN     = 4;
  localparam int B_PORT_EN    = 3;
  localparam int B_TIMER_FLAG = 2;
  localparam int B_EXT_FLAG   = 1;
  localparam int B_PORT_FLAG  = 0;

  // Other field positions
  localparam int B_EDGE_POL   = 0;
  localparam int B_SLEEP      = 0;
  localparam int B_SLEEP_ARM  = 1;
  localparam int B_EV_EXT     = 0;
  localparam int B_EV_TIMER   = 1;
  localparam int B_EV_PORT    = 2;
  localparam int B_EV_WAKE    = 3;

  // Reset values
  localparam logic [7:0]        RST_CORE_CTL = 8'h00;
  localparam logic [7:0]        RST_PFLAGS   = 8'h00;
  localparam logic [7:0]        RST_PENABLE  = 8'h00;
  localparam logic [7:0]        RST_OPTION   = 8'h01;
  localparam logic [PORT_W-1:0] RST_PIN_MASK = 8'h00;
  localparam logic [7:0]        RST_TICK     = 8'h00;
  localparam logic [EV_W-1:0]   RST_EV       = 4'h0;

  // Implemented bits of the second peripheral pair
  localparam logic [7:0] PFLAGS2_IMPL = 8'hF5;

  localparam logic [7:0]      TICK_MAX    = 8'hFF;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam logic [PC_W-1:0] RST_PC      = 13'h0000;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} cis_phase_t;

endpackage

// ===== design/cis_top.sv
// Interrupt flags, enables, wake-up and APB register file of the core interrupt sources
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
// Function
// R1: The external pin interrupt reacts only to a rising edge when polarity is one, falling when zero.
// R2: A valid edge of the selected polarity on the external pin sets the external pin flag.
// R3: With its enable clear the external pin flag raises no interrupt request.
// R4: Software clears the external pin flag itself, hardware never clears it.
// R5: A valid external edge wakes the core from sleep if its enable was set before sleep.
// R6: After wake-up the core branches to vector 0004h only with global enable set, else goes on.
// R7: The 8-bit tick counter wrapping from FFh to 00h sets the timer wrap flag.
// R8: The timer wrap enable gates whether the timer wrap flag requests an interrupt.
// R9: Any level change on an enabled pin of the second port sets the port change flag.
// R10: The port change enable gates whether the port change flag requests an interrupt.
// R11: A port pin joins change detection only when its per-pin mask bit is set.
// R12: A pin change coinciding with the port read at the start of Q2 may be lost.
// R13: The external pin flag is set only during the Q4 to Q1 phases.
// R14: The request is the OR of flag-and-enable pairs, peripherals under their enable, all under global.
module cis_top
  import cis_pkg::*;
#(
  parameter int PW = cis_pkg::PORT_W
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cis_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cis_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [cis_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       ext_irq_pin,
  input  wire logic [PW-1:0]              second_io_port,
  input  wire logic [7:0]                 periph_set_one,
  input  wire logic [7:0]                 periph_set_two,
  output logic                            core_irq_req,
  output logic                            sleeping,
  output logic                            wake_pulse,
  output logic                            vector_branch,
  output logic                            resume_next,
  output logic      [cis_pkg::PC_W-1:0]   vector_addr,
  output logic                            irq
);

  import cis_pkg::*;

  function automatic logic [DATA_W-1:0] zx8(input logic [7:0] v);
    zx8 = {24'h00_0000, v};
  endfunction

  function automatic logic [PW:0] agree(input logic [PW:0] a, input logic [PW:0] b,
                                        input logic [PW:0] old);
    agree = (~(a ^ b) & b) | ((a ^ b) & old);
  endfunction

  logic [PW:0]        s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  cis_phase_t         phase_reg, phase_next;
  logic [7:0]         ctl_reg, ctl_next;
  logic [7:0]         pfl1_reg, pfl1_next, pfl2_reg, pfl2_next;
  logic [7:0]         pen1_reg, pen1_next, pen2_reg, pen2_next;
  logic [7:0]         opt_reg, opt_next;
  logic [PW-1:0]      mask_reg, mask_next, latch_reg, latch_next;
  logic [7:0]         tick_reg, tick_next;
  logic               ext_prev_reg, ext_prev_next, ext_pend_reg, ext_pend_next;
  logic               rd_pend_reg, rd_pend_next;
  logic               sleep_reg, sleep_next, arm_reg, arm_next;
  logic               wake_reg, wake_next, vbr_reg, vbr_next, res_reg, res_next;
  logic [PC_W-1:0]    vaddr_reg, vaddr_next;
  logic [EV_W-1:0]    evst_reg, evst_next, even_reg, even_next;
  logic               irq_reg, irq_next, req_reg, req_next;
  logic [DATA_W-1:0]  prdata_reg, prdata_next;
  logic               pready_reg, pready_next, pslverr_reg, pslverr_next;

  logic               ack, wr, ext_f, ext_edge, ext_commit, latch_upd, mism;
  logic               rb_set, t0_set, tick_en, wake, tick_wr;
  logic               t_ext, t_tmr, t_port, t_per;
  logic [PW-1:0]      port_f;
  logic [DATA_W-1:0]  rd_val;
  logic               rd_hit;

  always_comb begin
    filt_next = agree(s2_reg, s3_reg, filt_reg);
    ext_f     = filt_reg[0];
    port_f    = filt_reg[PW:1];
    unique case (phase_reg)
      Q1: phase_next = Q2;
      Q2: phase_next = Q3;
      Q3: phase_next = Q4;
      Q4: phase_next = Q1;
    endcase
    tick_en = (phase_reg == Q4);

    ack = psel && penable && pready_reg;
    wr  = ack && pwrite && pstrb[0];

    // Edge of selected polarity only, on the filtered pin
    ext_edge      = opt_reg[B_EDGE_POL] ? (ext_f && !ext_prev_reg)   // R1
                                        : (!ext_f && ext_prev_reg);  // R1
    ext_prev_next = ext_f;
    // Pending edge waits for the Q4..Q1 window
    ext_commit    = (ext_pend_reg || ext_edge) && (phase_reg == Q4 || phase_reg == Q1); // R13
    ext_pend_next = (ext_pend_reg || ext_edge) && !ext_commit;

    // Port mismatch latch refreshed at Q2 after a port read; a change then is swallowed
    latch_upd  = rd_pend_reg && (phase_reg == Q2);                     // R12
    mism       = |((port_f ^ latch_reg) & mask_reg);                   // R11
    rb_set     = mism && !latch_upd;                                   // R9
    latch_next = latch_upd ? port_f : latch_reg;
    rd_pend_next = (rd_pend_reg && !latch_upd) ||
                   (ack && !pwrite && paddr == OFF_PORT);

    tick_wr   = wr && paddr == OFF_TICK;
    t0_set    = tick_en && tick_reg == TICK_MAX && !tick_wr;           // R7
    tick_next = tick_wr ? pwdata[7:0] : (tick_en ? tick_reg + 8'h01 : tick_reg);

    ctl_next  = (wr && paddr == OFF_CORE_CTL) ? pwdata[7:0] : ctl_reg;
    // Hardware sets win over a software clear in the same cycle
    ctl_next[B_EXT_FLAG]   = ctl_next[B_EXT_FLAG] | ext_commit;        // R2 R4
    ctl_next[B_TIMER_FLAG] = ctl_next[B_TIMER_FLAG] | t0_set;          // R7
    ctl_next[B_PORT_FLAG]  = ctl_next[B_PORT_FLAG] | rb_set;           // R9

    pfl1_next = ((wr && paddr == OFF_PFLAGS1) ? pwdata[7:0] : pfl1_reg) | periph_set_one;
    pfl2_next = (((wr && paddr == OFF_PFLAGS2) ? pwdata[7:0] : pfl2_reg) | periph_set_two)
                & PFLAGS2_IMPL;
    pen1_next = (wr && paddr == OFF_PENABLE1) ? pwdata[7:0] : pen1_reg;
    pen2_next = ((wr && paddr == OFF_PENABLE2) ? pwdata[7:0] : pen2_reg) & PFLAGS2_IMPL;
    opt_next  = (wr && paddr == OFF_OPTION) ? pwdata[7:0] : opt_reg;
    mask_next = (wr && paddr == OFF_PIN_MASK) ? pwdata[PW-1:0] : mask_reg;

    // Wake needs the enable as it stood when sleep began
    wake       = sleep_reg && arm_reg && ext_commit;                   // R5
    sleep_next = sleep_reg;
    arm_next   = arm_reg;
    if (wr && paddr == OFF_SLEEP && pwdata[B_SLEEP] && !sleep_reg) begin
      sleep_next = 1'b1;
      arm_next   = ctl_reg[B_EXT_EN];
    end
    if (wake) begin
      sleep_next = 1'b0;
    end
    wake_next  = wake;
    // Branch decision follows the wake pulse by one cycle
    vbr_next   = wake_reg && ctl_reg[B_GLOBAL_EN];                     // R6
    res_next   = wake_reg && !ctl_reg[B_GLOBAL_EN];                    // R6
    vaddr_next = vbr_next ? VECTOR_ADDR : vaddr_reg;                   // R6

    t_ext    = ctl_reg[B_EXT_FLAG] && ctl_reg[B_EXT_EN];               // R3
    t_tmr    = ctl_reg[B_TIMER_FLAG] && ctl_reg[B_TIMER_EN];           // R8
    t_port   = ctl_reg[B_PORT_FLAG] && ctl_reg[B_PORT_EN];             // R10
    t_per    = ctl_reg[B_PERIPH_EN] && (|(pfl1_reg & pen1_reg) || |(pfl2_reg & pen2_reg));
    req_next = ctl_reg[B_GLOBAL_EN] && (t_ext || t_tmr || t_port || t_per); // R14

    evst_next = evst_reg;
    if (wr && paddr == OFF_EV_CLEAR) begin
      evst_next = evst_reg & ~pwdata[EV_W-1:0];
    end
    evst_next = evst_next | {wake, rb_set, t0_set, ext_commit};
    even_next = (wr && paddr == OFF_EV_ENABLE) ? pwdata[EV_W-1:0] : even_reg;
    irq_next  = |(evst_next & even_next);

    rd_hit = 1'b1;
    unique case (paddr)
      OFF_CORE_CTL:  rd_val = zx8(ctl_reg);
      OFF_PFLAGS1:   rd_val = zx8(pfl1_reg);
      OFF_PFLAGS2:   rd_val = zx8(pfl2_reg);
      OFF_PENABLE1:  rd_val = zx8(pen1_reg);
      OFF_PENABLE2:  rd_val = zx8(pen2_reg);
      OFF_OPTION:    rd_val = zx8(opt_reg);
      OFF_PIN_MASK:  rd_val = zx8(8'(mask_reg));
      OFF_TICK:      rd_val = zx8(tick_reg);
      OFF_PORT:      rd_val = zx8(8'(port_f));
      OFF_SLEEP:     rd_val = zx8({6'b00_0000, arm_reg, sleep_reg});
      OFF_EV_STATUS: rd_val = zx8({4'h0, evst_reg});
      OFF_EV_CLEAR:  rd_val = zx8(8'h00);
      OFF_EV_ENABLE: rd_val = zx8({4'h0, even_reg});
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    // One wait state: data and error are registered in the same cycle as pready
    pready_next  = psel && penable && !pready_reg;
    prdata_next  = pready_next ? (pwrite ? 32'h0000_0000 : rd_val) : prdata_reg;
    pslverr_next = pready_next ? !rd_hit : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg       <= '0;
      s2_reg       <= '0;
      s3_reg       <= '0;
      filt_reg     <= '0;
      phase_reg    <= Q1;
      ctl_reg      <= RST_CORE_CTL;
      pfl1_reg     <= RST_PFLAGS;
      pfl2_reg     <= RST_PFLAGS;
      pen1_reg     <= RST_PENABLE;
      pen2_reg     <= RST_PENABLE;
      opt_reg      <= RST_OPTION;
      mask_reg     <= RST_PIN_MASK;
      latch_reg    <= '0;
      tick_reg     <= RST_TICK;
      ext_prev_reg <= 1'b0;
      ext_pend_reg <= 1'b0;
      rd_pend_reg  <= 1'b0;
      sleep_reg    <= 1'b0;
      arm_reg      <= 1'b0;
      wake_reg     <= 1'b0;
      vbr_reg      <= 1'b0;
      res_reg      <= 1'b0;
      vaddr_reg    <= RST_PC;
      evst_reg     <= RST_EV;
      even_reg     <= RST_EV;
      irq_reg      <= 1'b0;
      req_reg      <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
    end else begin
      s1_reg       <= {second_io_port, ext_irq_pin};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      filt_reg     <= filt_next;
      phase_reg    <= phase_next;
      ctl_reg      <= ctl_next;
      pfl1_reg     <= pfl1_next;
      pfl2_reg     <= pfl2_next;
      pen1_reg     <= pen1_next;
      pen2_reg     <= pen2_next;
      opt_reg      <= opt_next;
      mask_reg     <= mask_next;
      latch_reg    <= latch_next;
      tick_reg     <= tick_next;
      ext_prev_reg <= ext_prev_next;
      ext_pend_reg <= ext_pend_next;
      rd_pend_reg  <= rd_pend_next;
      sleep_reg    <= sleep_next;
      arm_reg      <= arm_next;
      wake_reg     <= wake_next;
      vbr_reg      <= vbr_next;
      res_reg      <= res_next;
      vaddr_reg    <= vaddr_next;
      evst_reg     <= evst_next;
      even_reg     <= even_next;
      irq_reg      <= irq_next;
      req_reg      <= req_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign core_irq_req  = req_reg;
  assign sleeping      = sleep_reg;
  assign wake_pulse    = wake_reg;
  assign vector_branch = vbr_reg;
  assign resume_next   = res_reg;
  assign vector_addr   = vaddr_reg;
  assign irq           = irq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_edge_polarity;
    $rose(ext_pend_reg) |-> $past(opt_reg[B_EDGE_POL]) == $past(ext_f);
  endproperty
  a_edge_polarity: assert property (p_edge_polarity) // R1
    else $error("pending external edge has wrong polarity");

  property p_edge_sets_flag;
    ext_edge |-> ##[1:3] ctl_reg[B_EXT_FLAG] || $past(wr && paddr == OFF_CORE_CTL);
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag) // R2
    else $error("external edge did not set the flag");

  property p_flag_phase;
    $rose(ctl_reg[B_EXT_FLAG]) && !$past(wr && paddr == OFF_CORE_CTL)
      |-> $past(phase_reg) == Q4 || $past(phase_reg) == Q1;
  endproperty
  a_flag_phase: assert property (p_flag_phase) // R13
    else $error("external flag set outside Q4 to Q1");

  property p_req_gated;
    $past(!t_ext && !t_tmr && !t_port && !t_per) |-> !core_irq_req;
  endproperty
  a_req_gated: assert property (p_req_gated) // R3
    else $error("request raised with no enabled flag");

  property p_req_global;
    core_irq_req |-> $past(ctl_reg[B_GLOBAL_EN]);
  endproperty
  a_req_global: assert property (p_req_global) // R14
    else $error("request raised without global enable");

  property p_timer_req;
    ctl_reg[B_GLOBAL_EN] && t_tmr |=> core_irq_req;
  endproperty
  a_timer_req: assert property (p_timer_req) // R8
    else $error("enabled timer flag gave no request");

  property p_wrap;
    tick_en && tick_reg == TICK_MAX && !tick_wr |=> tick_reg == 8'h00 && ctl_reg[B_TIMER_FLAG];
  endproperty
  a_wrap: assert property (p_wrap) // R7
    else $error("tick wrap did not set the timer flag");

  property p_port_change;
    mism && !latch_upd |=> ctl_reg[B_PORT_FLAG];
  endproperty
  a_port_change: assert property (p_port_change) // R9
    else $error("masked port change did not set the flag");

  property p_port_masked;
    $rose(ctl_reg[B_PORT_FLAG]) |-> $past(mism) || $past(wr && paddr == OFF_CORE_CTL);
  endproperty
  a_port_masked: assert property (p_port_masked) // R11
    else $error("port flag set with no masked change");

  property p_latch_q2;
    latch_reg != $past(latch_reg) |-> $past(phase_reg) == Q2;
  endproperty
  a_latch_q2: assert property (p_latch_q2) // R12
    else $error("port latch refreshed outside Q2");

  property p_wake;
    sleep_reg && arm_reg && ext_commit |=> !sleep_reg && wake_pulse ##1 !wake_pulse;
  endproperty
  a_wake: assert property (p_wake) // R5
    else $error("armed edge did not wake the core");

  property p_vector;
    wake_pulse |-> ##1 (vector_branch == $past(ctl_reg[B_GLOBAL_EN]))
                   && (resume_next != vector_branch)
                   && (!vector_branch || vector_addr == VECTOR_ADDR);
  endproperty
  a_vector: assert property (p_vector) // R6
    else $error("wake branch does not follow global enable");

  c_ext_irq:   cover property (ext_edge ##[1:3] $rose(core_irq_req));
  c_wake_vec:  cover property (wake_pulse ##1 vector_branch);
  c_wake_cont: cover property (wake_pulse ##1 resume_next);
  c_port_lost: cover property (mism && latch_upd);

endmodule

// ===== verif/cis_pin_model.sv
// Model of the external interrupt pin and the second port pins
`timescale 1ns/1ns
module cis_pin_model (
  input  wire logic       pclk,
  input  wire logic       ext_want,
  input  wire logic [7:0] port_want,
  output logic            ext_irq_pin,
  output logic      [7:0] second_io_port
);
  // Pins start low so the synchroniser sees no false edge at release
  initial begin
    ext_irq_pin    = 1'b0;
    second_io_port = 8'h00;
  end
  // Levels move only just after a clock edge, like a slow board driver
  always @(posedge pclk) begin
    ext_irq_pin    <= ext_want;
    second_io_port <= port_want;
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the core interrupt source block
`timescale 1ns/1ns
module testbench;
  import cis_pkg::*;
  localparam logic [7:0] GE = 8'h01 << B_GLOBAL_EN;
  localparam logic [7:0] TE = 8'h01 << B_TIMER_EN;
  localparam logic [7:0] EE = 8'h01 << B_EXT_EN;
  localparam logic [7:0] PE = 8'h01 << B_PORT_EN;
  localparam logic [7:0] TF = 8'h01 << B_TIMER_FLAG;
  localparam logic [7:0] EF = 8'h01 << B_EXT_FLAG;
  localparam logic [7:0] PF = 8'h01 << B_PORT_FLAG;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, port_want, second_io_port, m, v, pset1;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        ext_want, ext_irq_pin, core_irq_req, sleeping, wake_pulse;
  logic        vector_branch, resume_next, irq;
  logic [12:0] vector_addr;
  logic [32:0] expq[$];
  int          n_mismatch, checks_done;
  logic [7:0]  ra[6] = '{OFF_CORE_CTL, OFF_PFLAGS1, OFF_PFLAGS2, OFF_PENABLE1, OFF_OPTION,
                         OFF_PIN_MASK};
  logic [7:0]  rv[6] = '{RST_CORE_CTL, RST_PFLAGS, RST_PFLAGS, RST_PENABLE, RST_OPTION,
                         RST_PIN_MASK};

  cis_pin_model cis_pin_model_i (.pclk(pclk), .ext_want(ext_want), .port_want(port_want),
    .ext_irq_pin(ext_irq_pin), .second_io_port(second_io_port));
  cis_top cis_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .second_io_port(second_io_port), .periph_set_one(pset1), .periph_set_two(8'h00),
    .core_irq_req(core_irq_req), .sleeping(sleeping), .wake_pulse(wake_pulse),
    .vector_branch(vector_branch), .resume_next(resume_next), .vector_addr(vector_addr),
    .irq(irq));

  always #25 pclk = ~pclk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Read data is judged by the monitor, against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0)
        check({pslverr, prdata}, 33'h1_DEAD_BEEF);
      else
        check({pslverr, prdata}, expq.pop_front());
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr)
      expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000, {25'h000_0000, e});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_wake();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wake_pulse !== 1'b1 && n < 30);
    if (n >= 30) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pstrb = 4'hF; ext_want = 0; port_want = 0; pset1 = 0;
    n_mismatch = 0; checks_done = 0;
    void'($urandom(38));
    wait_cyc(20);
    presetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b0, 8'h40, 32'h0000_0000, 33'h1_0000_0000);
    $display("test reset_and_map done");
    // Tick cleared first so a wrap flag cannot sneak into reads
    wr(OFF_TICK, 8'h00);
    ext_want <= 1'b1; wait_cyc(12); rd(OFF_CORE_CTL, EF);
    wait_cyc(20); rd(OFF_CORE_CTL, EF);
    wr(OFF_CORE_CTL, 8'h00);
    ext_want <= 1'b0; wait_cyc(12); rd(OFF_CORE_CTL, 8'h00);
    wr(OFF_OPTION, 8'h00);
    ext_want <= 1'b1; wait_cyc(12); rd(OFF_CORE_CTL, 8'h00);
    ext_want <= 1'b0; wait_cyc(12); rd(OFF_CORE_CTL, EF);
    wr(OFF_CORE_CTL, EF | GE); wait_cyc(2); check(core_irq_req, 1'b0);
    wr(OFF_CORE_CTL, EF | GE | EE); wait_cyc(2); check(core_irq_req, 1'b1);
    wr(OFF_CORE_CTL, EF | EE); wait_cyc(2); check(core_irq_req, 1'b0);
    pstrb <= 4'h0; wr(OFF_CORE_CTL, 8'h00); pstrb <= 4'hF;
    rd(OFF_CORE_CTL, EF | EE);
    $display("test ext_pin done");
    wr(OFF_CORE_CTL, 8'h00); wr(OFF_TICK, 8'hFE);
    wait_cyc(16); rd(OFF_CORE_CTL, TF);
    wr(OFF_CORE_CTL, TF | GE); wait_cyc(2); check(core_irq_req, 1'b0);
    wr(OFF_CORE_CTL, TF | GE | TE); wait_cyc(2); check(core_irq_req, 1'b1);
    $display("test timer_wrap done");
    wr(OFF_CORE_CTL, 8'h00); wr(OFF_TICK, 8'h00);
    // Bit 0 always watched, bit 7 always unwatched and moving
    m = (8'($urandom) | 8'h01) & 8'h7F;
    v = (8'($urandom) | 8'h80) & ~m;
    wr(OFF_PIN_MASK, m);
    port_want <= v; wait_cyc(12); rd(OFF_CORE_CTL, 8'h00);
    port_want <= v ^ 8'h01; wait_cyc(12); rd(OFF_CORE_CTL, PF);
    rd(OFF_PORT, v ^ 8'h01);
    wr(OFF_CORE_CTL, 8'h00); wait_cyc(8); rd(OFF_CORE_CTL, 8'h00);
    port_want <= v; wait_cyc(12);
    wr(OFF_CORE_CTL, PF | GE); wait_cyc(2); check(core_irq_req, 1'b0);
    wr(OFF_CORE_CTL, PF | GE | PE); wait_cyc(2); check(core_irq_req, 1'b1);
    $display("test port_change done");
    rd(OFF_PORT, v);
    pset1 <= 8'h10; wait_cyc(1); pset1 <= 8'h00;
    wr(OFF_PFLAGS2, 8'hFF); rd(OFF_PFLAGS2, PFLAGS2_IMPL);
    wr(OFF_PENABLE1, 8'h10); wr(OFF_CORE_CTL, GE);
    wait_cyc(2); check(core_irq_req, 1'b0);
    wr(OFF_CORE_CTL, GE | (8'h01 << B_PERIPH_EN));
    wait_cyc(2); check(core_irq_req, 1'b1);
    rd(OFF_PFLAGS1, 8'h10);
    $display("test periph done");
    wr(OFF_CORE_CTL, EE | GE); wr(OFF_OPTION, 8'h01); wr(OFF_TICK, 8'h00);
    wr(OFF_SLEEP, 8'h01); wait_cyc(2); check(sleeping, 1'b1);
    ext_want <= 1'b1; wait_wake();
    check({vector_branch, resume_next}, 2'b10);
    wait_cyc(1); check(vector_addr, VECTOR_ADDR);
    wr(OFF_CORE_CTL, EE); ext_want <= 1'b0; wait_cyc(12);
    wr(OFF_SLEEP, 8'h01); ext_want <= 1'b1; wait_wake();
    check({vector_branch, resume_next}, 2'b01);
    $display("test wake done");
    wr(OFF_EV_CLEAR, 8'h0F); wr(OFF_EV_ENABLE, 8'h01 << B_EV_EXT);
    wait_cyc(2); check(irq, 1'b0);
    ext_want <= 1'b0; wait_cyc(12); ext_want <= 1'b1; wait_cyc(12);
    check(irq, 1'b1);
    wr(OFF_EV_CLEAR, 8'h01 << B_EV_EXT); wait_cyc(2); check(irq, 1'b0);
    ext_want <= 1'b0; wait_cyc(12); ext_want <= 1'b1; wait_cyc(12);
    wr(OFF_EV_ENABLE, 8'h00); wait_cyc(2); check(irq, 1'b0);
    $display("test event_irq done");
    complete_run();
  end
endmodule
